// ==== src/slmsf_map.svh ====
`ifndef SLMSF_MAP_SVH
`define SLMSF_MAP_SVH
`define SLMSF_SRC_FORCE       3'h0
`define SLMSF_SRC_SPEED       3'h1
`define SLMSF_SRC_ACCEL       3'h2
`define SLMSF_SRC_ERROR       3'h3
`define SLMSF_SRC_OFF         3'h4
`define SLMSF_FORCE_THR_RST   10'h0C8
`define SLMSF_SPEED_THR_RST   14'h0000
`define SLMSF_ACCEL_THR_RST   15'h0000
`define SLMSF_ERR_THR_RST     14'h0000
`define SLMSF_LAG_TC_RST      16'h0064
`define SLMSF_FREQ_RST        13'h1388
`define SLMSF_FREQ_BYPASS     13'h1388
`define SLMSF_QUAL_RST        10'h032
`define SLMSF_QUAL_MIN        10'h032
`define SLMSF_NOTCH_EN_RST    2'h0
`define SLMSF_CLK_HZ          250000000
`define SLMSF_SAMPLE_HZ       31250
`define SLMSF_SAMPLE_DIV      (`SLMSF_CLK_HZ / `SLMSF_SAMPLE_HZ)
`define SLMSF_SAMPLE_US       32
`define SLMSF_TC_UNIT_US      10
`define SLMSF_ACCEL_SCALE     32'h00007A12
`define SLMSF_F_PER_HZ_Q20    9'h0D3
`define SLMSF_QINV_NUM_Q12    20'h64000
`define SLMSF_NOTCH_HZ        13'h1388
`define SLMSF_NOTCH_Q         10'h046
`endif

// ==== src/slmsf_pkg.sv ====
`default_nettype none
package slmsf_pkg;
  typedef struct packed {
    logic [2:0]  src;
    logic [9:0]  force_thr;
    logic [13:0] speed_thr;
    logic [14:0] accel_thr;
    logic [13:0] err_thr;
    logic [15:0] lag_tc;
    logic [12:0] freq;
    logic [9:0]  qual;
    logic [1:0]  notch_en;
  } slmsf_cfg_t;
  typedef struct packed {
    logic signed [15:0] force_ref;
    logic signed [15:0] speed_ref;
    logic signed [31:0] pos_err;
  } slmsf_sample_t;
  typedef struct packed {
    logic pos_ctrl;
    logic ip_ctrl;
  } slmsf_loop_t;
endpackage
`default_nettype wire

// ==== src/slmsf_top.sv ====
`include "slmsf_map.svh"
`timescale 1ns/1ps
`default_nettype none

module slmsf_svf (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_en,
  input  wire logic signed [31:0] i_x,
  input  wire logic        [21:0] i_f,
  input  wire logic        [15:0] i_qinv,
  output logic signed      [31:0] o_low,
  output logic signed      [31:0] o_notch
);
  logic signed [31:0] low_reg;
  logic signed [31:0] band_reg;
  wire  signed [63:0] qb     = $signed({1'b0, i_qinv}) * band_reg;
  wire  signed [31:0] damp   = qb[43:12];
  wire  signed [31:0] high   = i_x - low_reg - damp;
  wire  signed [63:0] fb     = $signed({1'b0, i_f}) * band_reg;
  wire  signed [63:0] fh     = $signed({1'b0, i_f}) * high;
  assign o_low   = low_reg;
  assign o_notch = i_x - damp;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_reg  <= 32'h00000000;
      band_reg <= 32'h00000000;
    end else if (i_en) begin
      low_reg  <= low_reg + fb[51:20];
      band_reg <= band_reg + fh[51:20];
    end
  end
endmodule // slmsf_svf

module slmsf_top #(
  parameter int SAMPLE_DIV = `SLMSF_SAMPLE_DIV
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_cfg_wr,
  input  wire slmsf_pkg::slmsf_cfg_t i_cfg,
  input  wire slmsf_pkg::slmsf_loop_t i_loop,
  input  wire slmsf_pkg::slmsf_sample_t i_sample,
  output logic                       o_sample_tick,
  output logic                       o_p_only,
  output logic                       o_force_valid,
  output logic signed [15:0]         o_force_filt
);
  slmsf_pkg::slmsf_cfg_t    cfg_reg;
  slmsf_pkg::slmsf_sample_t smp_reg;
  logic signed [15:0] prev_speed_reg;
  logic        [12:0] div_reg;
  logic               tick_reg;
  logic               p_only_reg;
  logic               valid_reg;
  logic signed [15:0] out_reg;
  logic signed [31:0] lag_reg;

  // sample divider
  wire div_end = (div_reg == 13'(SAMPLE_DIV - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_reg  <= 13'h0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_end ? 13'h0000 : div_reg + 13'h0001;
      tick_reg <= div_end;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_reg.src       <= `SLMSF_SRC_FORCE;
      cfg_reg.force_thr <= `SLMSF_FORCE_THR_RST;
      cfg_reg.speed_thr <= `SLMSF_SPEED_THR_RST;
      cfg_reg.accel_thr <= `SLMSF_ACCEL_THR_RST;
      cfg_reg.err_thr   <= `SLMSF_ERR_THR_RST;
      cfg_reg.lag_tc    <= `SLMSF_LAG_TC_RST;
      cfg_reg.freq      <= `SLMSF_FREQ_RST;
      cfg_reg.qual      <= `SLMSF_QUAL_RST;
      cfg_reg.notch_en  <= `SLMSF_NOTCH_EN_RST;
    end else if (i_cfg_wr) begin
      cfg_reg <= i_cfg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      smp_reg        <= '0;
      prev_speed_reg <= 16'h0000;
    end else if (tick_reg) begin
      smp_reg        <= i_sample;
      prev_speed_reg <= smp_reg.speed_ref;
    end
  end

  // mode switch detection
  wire        [15:0] force_mag = smp_reg.force_ref[15] ? 16'(-smp_reg.force_ref)
                                                       : smp_reg.force_ref;
  wire        [15:0] speed_mag = smp_reg.speed_ref[15] ? 16'(-smp_reg.speed_ref)
                                                       : smp_reg.speed_ref;
  wire signed [16:0] dv        = 17'(smp_reg.speed_ref) - 17'(prev_speed_reg);
  wire        [16:0] dv_mag    = dv[16] ? 17'(-dv) : dv;
  wire        [47:0] accel_mag = {31'h00000000, dv_mag} * {16'h0000, `SLMSF_ACCEL_SCALE};
  wire        [31:0] err_mag   = smp_reg.pos_err[31] ? 32'(-smp_reg.pos_err)
                                                     : smp_reg.pos_err;
  wire hit_force = force_mag > {6'h00, cfg_reg.force_thr};
  wire hit_speed = speed_mag > {2'h0, cfg_reg.speed_thr};
  wire hit_accel = accel_mag > {33'h000000000, cfg_reg.accel_thr};
  wire hit_err   = i_loop.pos_ctrl & (err_mag > {18'h00000, cfg_reg.err_thr});
  wire sel_hit   = (cfg_reg.src == `SLMSF_SRC_FORCE) ? hit_force :
                   (cfg_reg.src == `SLMSF_SRC_SPEED) ? hit_speed :
                   (cfg_reg.src == `SLMSF_SRC_ACCEL) ? hit_accel :
                   (cfg_reg.src == `SLMSF_SRC_ERROR) ? hit_err : 1'b0;
  wire p_only_next = sel_hit & ~i_loop.ip_ctrl;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      p_only_reg <= 1'b0;
    end else begin
      p_only_reg <= p_only_next;
    end
  end

  // first order lag, 8 fraction bits
  wire signed [31:0] x32     = {{8{smp_reg.force_ref[15]}}, smp_reg.force_ref, 8'h00};
  wire signed [39:0] diff    = 40'(x32) - 40'(lag_reg);
  wire signed [39:0] num     = diff * 40'(`SLMSF_SAMPLE_US);
  wire        [20:0] den     = 21'({5'h00, cfg_reg.lag_tc} * 21'(`SLMSF_TC_UNIT_US))
                               + 21'(`SLMSF_SAMPLE_US);
  wire signed [39:0] lag_step = num / $signed({19'h00000, den});
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lag_reg <= 32'h00000000;
    end else if (tick_reg) begin
      lag_reg <= lag_reg + lag_step[31:0];
    end
  end

  // second filter
  wire        [9:0]  qual_c  = (cfg_reg.qual < `SLMSF_QUAL_MIN) ? `SLMSF_QUAL_MIN : cfg_reg.qual;
  wire        [19:0] qinv_w  = `SLMSF_QINV_NUM_Q12 / {10'h000, qual_c};
  wire        [21:0] f2      = 22'({9'h000, cfg_reg.freq} * {13'h0000, `SLMSF_F_PER_HZ_Q20});
  wire signed [31:0] f2_low;
  wire               bypass2 = (cfg_reg.freq == `SLMSF_FREQ_BYPASS);
  wire signed [31:0] stage2  = bypass2 ? lag_reg : f2_low;
  slmsf_svf u_second (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_en    (tick_reg),
    .i_x     (lag_reg),
    .i_f     (f2),
    .i_qinv  (qinv_w[15:0]),
    .o_low   (f2_low),
    .o_notch ()
  );

  // notch stages in series
  localparam logic [21:0] NOTCH_F = 22'(`SLMSF_NOTCH_HZ * `SLMSF_F_PER_HZ_Q20);
  localparam logic [19:0] NOTCH_QI = `SLMSF_QINV_NUM_Q12 / 20'(`SLMSF_NOTCH_Q);
  wire signed [31:0] chain [0:2];
  assign chain[0] = stage2;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_notch
      wire signed [31:0] n_out;
      slmsf_svf u_notch (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_en    (tick_reg),
        .i_x     (chain[g]),
        .i_f     (NOTCH_F),
        .i_qinv  (NOTCH_QI[15:0]),
        .o_low   (),
        .o_notch (n_out)
      );
      assign chain[g+1] = cfg_reg.notch_en[g] ? n_out : chain[g];
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_reg   <= 16'h0000;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= tick_reg;
      if (tick_reg) begin
        out_reg <= chain[2][23:8];
      end
    end
  end

  assign o_sample_tick = tick_reg;
  assign o_p_only      = p_only_reg;
  assign o_force_valid = valid_reg;
  assign o_force_filt  = out_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_reset_defaults: assert property ($past(i_rst) && !i_rst && !$past(i_cfg_wr) |->
      cfg_reg.src == `SLMSF_SRC_FORCE && cfg_reg.force_thr == `SLMSF_FORCE_THR_RST
      && cfg_reg.speed_thr == `SLMSF_SPEED_THR_RST && cfg_reg.accel_thr == `SLMSF_ACCEL_THR_RST
      && cfg_reg.err_thr == `SLMSF_ERR_THR_RST && cfg_reg.lag_tc == `SLMSF_LAG_TC_RST
      && cfg_reg.freq == `SLMSF_FREQ_RST && cfg_reg.qual == `SLMSF_QUAL_RST
      && cfg_reg.notch_en == `SLMSF_NOTCH_EN_RST)
    else $error("config reset defaults wrong");
  chk_force_switch: assert property (cfg_reg.src == 3'h0 && !i_loop.ip_ctrl
      && force_mag > {6'h00, cfg_reg.force_thr} |=> o_p_only)
    else $error("force level did not force P control");
  chk_speed_switch: assert property (cfg_reg.src == 3'h1 && !i_loop.ip_ctrl
      && speed_mag > {2'h0, cfg_reg.speed_thr} |=> o_p_only)
    else $error("speed level did not force P control");
  chk_accel_switch: assert property (cfg_reg.src == 3'h2 && !i_loop.ip_ctrl
      && dv_mag * 17'd31250 > 32'(cfg_reg.accel_thr) && dv_mag < 17'h00100 |=> o_p_only)
    else $error("acceleration did not force P control");
  chk_error_switch: assert property (cfg_reg.src == 3'h3 && !i_loop.ip_ctrl
      && i_loop.pos_ctrl && err_mag > 32'(cfg_reg.err_thr) |=> o_p_only)
    else $error("position error did not force P control");
  chk_error_gate: assert property (cfg_reg.src == 3'h3 && !i_loop.pos_ctrl |=> !o_p_only)
    else $error("error source acted outside position control");
  chk_switch_off: assert property (cfg_reg.src >= 3'h4 |=> !o_p_only)
    else $error("P control while switch disabled");
  chk_ip_blocks: assert property (i_loop.ip_ctrl |=> !o_p_only)
    else $error("mode switch active under I-P control");
  chk_bypass_path: assert property (tick_reg && bypass2 && cfg_reg.notch_en == 2'h0
      |=> o_force_valid && o_force_filt == $past(lag_reg[23:8]))
    else $error("bypassed chain output differs from lag stage");
  chk_lag_zero: assert property (tick_reg && cfg_reg.lag_tc == 16'h0000
      |=> lag_reg == $past(x32))
    else $error("zero lag constant did not pass through");
  chk_tick_space: assert property (tick_reg |=> !tick_reg [*3])
    else $error("sample ticks too close");
  chk_tick_phase: assert property (tick_reg |-> div_reg == 13'h0000)
    else $error("sample tick out of phase with divider");
  chk_div_range: assert property (div_reg < 13'(SAMPLE_DIV))
    else $error("divider count out of range");

  // return to PI and reset state
  chk_force_return: assert property (cfg_reg.src == 3'h0
      && force_mag <= {6'h00, cfg_reg.force_thr} |=> !o_p_only)
    else $error("force level below threshold kept P control");
  chk_speed_return: assert property (cfg_reg.src == 3'h1
      && speed_mag <= {2'h0, cfg_reg.speed_thr} |=> !o_p_only)
    else $error("speed level below threshold kept P control");
  chk_accel_return: assert property (cfg_reg.src == 3'h2
      && dv_mag == 17'h00000 |=> !o_p_only)
    else $error("steady speed kept P control");
  chk_error_return: assert property (cfg_reg.src == 3'h3
      && err_mag <= 32'(cfg_reg.err_thr) |=> !o_p_only)
    else $error("small position error kept P control");
  chk_reset_outputs: assert property ($past(i_rst) && !i_rst |->
      !o_p_only && !o_force_valid && o_force_filt == 16'h0000)
    else $error("outputs not cleared by reset");

  // config and sample handshakes
  chk_cfg_load: assert property (i_cfg_wr |=> cfg_reg == $past(i_cfg))
    else $error("config write not taken on the next edge");
  chk_sample_capture: assert property (tick_reg |=> smp_reg == $past(i_sample))
    else $error("sample not captured on tick");
  chk_valid_pulse: assert property (o_force_valid == $past(tick_reg))
    else $error("valid pulse not one cycle after tick");
  chk_filt_holds: assert property (!tick_reg |=> $stable(o_force_filt))
    else $error("filtered force changed between samples");
  chk_lag_hold: assert property (!tick_reg |=> $stable(lag_reg))
    else $error("lag stage moved between samples");
  chk_qual_clamp: assert property (qinv_w <= 20'h02000)
    else $error("quality below the minimum reached the damping");

  // filter chain selection
  chk_notch_off: assert property (tick_reg && cfg_reg.notch_en == 2'h0
      |=> o_force_filt == $past(stage2[23:8]))
    else $error("disabled notches changed the force path");
  chk_second_used: assert property (tick_reg && !bypass2 && cfg_reg.notch_en == 2'h0
      |=> o_force_filt == $past(f2_low[23:8]))
    else $error("second filter output not used");
  chk_notch_first: assert property (tick_reg && cfg_reg.notch_en == 2'h1
      |=> o_force_filt == $past(g_notch[0].n_out[23:8]))
    else $error("first notch output not used");
  chk_notch_second: assert property (tick_reg && cfg_reg.notch_en[1]
      |=> o_force_filt == $past(g_notch[1].n_out[23:8]))
    else $error("second notch output not used");

  cov_p_only_rise: cover property (!o_p_only ##1 o_p_only);
  cov_notches_on: cover property (tick_reg && cfg_reg.notch_en == 2'h3);
  cov_error_switch: cover property (cfg_reg.src == 3'h3 && i_loop.pos_ctrl ##1 o_p_only);
  cov_second_active: cover property (tick_reg && !bypass2);
  cov_accel_switch: cover property (cfg_reg.src == 3'h2 ##1 o_p_only);
endmodule // slmsf_top
`default_nettype wire

// ==== testbench/slmsf_loop_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far-side loops: present a new sample just after each capture
module slmsf_loop_model (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_load,
  input  wire slmsf_pkg::slmsf_sample_t i_next,
  input  wire slmsf_pkg::slmsf_loop_t   i_next_loop,
  output var slmsf_pkg::slmsf_sample_t  o_sample,
  output var slmsf_pkg::slmsf_loop_t    o_loop
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sample <= '0;
      o_loop   <= '0;
    end else if (i_load) begin
      o_sample <= i_next;
      o_loop   <= i_next_loop;
    end
  end
endmodule // slmsf_loop_model
`default_nettype wire

// ==== testbench/slmsf_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module slmsf_top_tb;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      cfg_wr = 1'b0;
  slmsf_pkg::slmsf_cfg_t     cfg;
  slmsf_pkg::slmsf_cfg_t     cfg_in = '0;
  slmsf_pkg::slmsf_sample_t  nxt = '0;
  slmsf_pkg::slmsf_sample_t  smp_w;
  slmsf_pkg::slmsf_loop_t    nloop = '0;
  slmsf_pkg::slmsf_loop_t    loop_w;
  logic                      tick, p_only, fvalid;
  logic signed [15:0]        filt;
  int                        miscompares = 0;
  int                        checked = 0;
  int                        cycles = 0;

  always #2 clk = ~clk;

  slmsf_top #(.SAMPLE_DIV(8)) slmsf_top_i (.i_clk(clk), .i_rst(rst), .i_cfg_wr(cfg_wr),
    .i_cfg(cfg_in), .i_loop(loop_w), .i_sample(smp_w), .o_sample_tick(tick),
    .o_p_only(p_only), .o_force_valid(fvalid), .o_force_filt(filt));
  slmsf_loop_model slmsf_loop_model_i (.i_clk(clk), .i_rst(rst), .i_load(fvalid),
    .i_next(nxt), .i_next_loop(nloop), .o_sample(smp_w), .o_loop(loop_w));

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_for(input bit on_tick);
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      if ((on_tick ? tick : fvalid) === 1'b1) return;
    end
    miscompares++;
    $display("[FAIL] %0t no sample handshake", $time);
  endtask

  task automatic wcfg();
    @(posedge clk);
    cfg_in <= cfg;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  // one sample through the loop, then the mode seen from it
  task automatic smp(input logic signed [15:0] f, input logic signed [15:0] s,
                     input logic signed [31:0] e, input logic [1:0] lp, input logic exp);
    nxt <= {f, s, e};
    nloop <= lp;
    wait_for(1'b0);
    wait_for(1'b1);
    #1 check({15'h0000, fvalid}, 16'h0001);
    repeat (2) @(posedge clk);
    #1 check({15'h0000, p_only}, {15'h0000, exp});
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    cfg = {3'h0, 10'h0C8, 14'h0000, 15'h0000, 14'h0000, 16'h0064, 13'h1388, 10'h032, 2'h0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 check({15'h0000, p_only}, 16'h0000);
    check(filt, 16'h0000);
    smp(16'sh00C9, 16'sh0000, 32'sh0, 2'h0, 1'b1);
    smp(16'sh00C8, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    smp(-16'sh00C9, 16'sh0000, 32'sh0, 2'h0, 1'b1);
    smp(16'sh0320, 16'sh0000, 32'sh0, 2'h1, 1'b0);
    cfg.src = 3'h1;
    cfg.speed_thr = 14'h0064;
    wcfg();
    smp(16'sh0000, 16'sh0065, 32'sh0, 2'h0, 1'b1);
    smp(16'sh0000, 16'sh0064, 32'sh0, 2'h0, 1'b0);
    cfg.src = 3'h2;
    cfg.accel_thr = 15'h7530;
    wcfg();
    smp(16'sh0000, 16'sh0064, 32'sh0, 2'h0, 1'b0);
    smp(16'sh0000, 16'sh0065, 32'sh0, 2'h0, 1'b1);
    smp(16'sh0000, 16'sh0065, 32'sh0, 2'h0, 1'b0);
    cfg.src = 3'h3;
    cfg.err_thr = 14'h000A;
    wcfg();
    smp(16'sh0000, 16'sh0000, 32'sh0B, 2'h2, 1'b1);
    smp(16'sh0000, 16'sh0000, 32'sh0A, 2'h2, 1'b0);
    smp(16'sh0000, 16'sh0000, 32'sh0B, 2'h0, 1'b0);
    cfg.src = 3'h4;
    cfg.lag_tc = 16'h0000;
    wcfg();
    repeat (3) smp(16'sh012C, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    smp(16'sh012C, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    check(filt, 16'h012C);
    cfg.lag_tc = 16'h0064;
    wcfg();
    repeat (2) smp(16'sh0000, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    check({15'h0000, filt > 16'sh0000 && filt < 16'sh012C}, 16'h0001);
    cfg.lag_tc = 16'h0000;
    cfg.freq = 13'h0064;
    wcfg();
    repeat (4) smp(16'sh0000, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    repeat (2) smp(16'sh012C, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    check({15'h0000, filt < 16'sh012C}, 16'h0001);
    cfg.freq = 13'h1388;
    cfg.notch_en = 2'h1;
    wcfg();
    repeat (8) smp(16'sh0000, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    repeat (3) smp(16'sh012C, 16'sh0000, 32'sh0, 2'h0, 1'b0);
    check({15'h0000, filt < 16'sh012C}, 16'h0001);
    print_verdict();
  end
endmodule // slmsf_top_tb
`default_nettype wire
